// [verilog/drive_load_protection_supervisor.sv]
`timescale 1ns/1ps
module drive_load_protection_supervisor
	import dlps_pkg::*;
#(
	parameter int TICK = TICK_CYCLES,
	parameter int UNIT = UNIT_CYCLES
)
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] outCurrent,
	input  wire logic [15:0] outFreq,
	input  wire logic [15:0] targetFreq,
	input  wire ramp_mode_type rampMode,
	input  wire logic        stopCmd,
	input  wire logic        outPhaseLoss,
	input  wire logic        inPhaseLoss,
	input  wire logic        contactorState,
	input  wire logic        fanFault,
	input  wire logic        updownActive,
	input  wire logic        savedClear,
	input  wire logic        multi_ramp_select_low,
	input  wire logic        multi_ramp_select_mid,
	input  wire logic        multi_ramp_select_high,
	output logic             programmable_output_terminal,
	output logic             olAlarm,
	output logic             outputCutoff,
	output logic             stallHold,
	output logic             decelRequest,
	output logic             suppressVoltage,
	output logic             fan_warn_only,
	output logic             useAltRamp,
	output logic [15:0]      rampTime,
	output logic [15:0]      rampSpan,
	output logic [31:0]      rampUnitCycles,
	output logic [15:0]      saved_frequency_display
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [NSYNC-1:0] pinRaw;
	logic [NSYNC-1:0] syncA;
	logic [NSYNC-1:0] syncB;
	assign pinRaw = {multi_ramp_select_high, multi_ramp_select_mid,
		multi_ramp_select_low, savedClear, updownActive, fanFault,
		contactorState, inPhaseLoss};
	logic outPlS;
	logic outPlA;
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : gSync
			always_ff @(posedge mclk)
			begin
				syncA[gi] <= rst ? 1'b0 : pinRaw[gi];
				syncB[gi] <= rst ? 1'b0 : syncA[gi];
			end
		end
	endgenerate
	always_ff @(posedge mclk)
	begin
		outPlA <= rst ? 1'b0 : outPhaseLoss;
		outPlS <= rst ? 1'b0 : outPlA;
	end
	logic inPlS, contS, fanS, udS, clrS;
	logic [2:0] mrS;
	assign {mrS, clrS, udS, fanS, contS, inPlS} = syncB;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [31:0] ctrl, olWarn, olTrip, rating, stall, freqCfg;
	logic [31:0] rampA, rampB;
	logic [7:0]  auxFunc;
	logic [4:0]  faults;
	logic [15:0] savedFreq;
	logic        wrEn;
	logic [7:0]  wrAddr;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= OFS_FAULT;
	endfunction

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	// write address and data are taken together; a lone half waits
	assign wrEn = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wrEn;
	assign s_axi_wready = wrEn;
	assign wrAddr = s_axi_awaddr;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else if (wrEn)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(wrAddr) ? 2'b00 : 2'b10;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ctrl <= RST_CTRL;
			olWarn <= RST_OLWARN;
			olTrip <= RST_OLTRIP;
			rating <= RST_RATING;
			stall <= RST_STALL;
			freqCfg <= RST_FREQ;
			rampA <= RST_RAMP;
			rampB <= RST_RAMP;
			auxFunc <= RST_AUX;
		end
		else if (wrEn)
		begin
			case (wrAddr)
				OFS_CTRL: ctrl <= merge(ctrl, s_axi_wdata, s_axi_wstrb);
				OFS_OLWARN:
					olWarn <= merge(olWarn, s_axi_wdata, s_axi_wstrb);
				OFS_OLTRIP:
					olTrip <= merge(olTrip, s_axi_wdata, s_axi_wstrb);
				OFS_RATING:
					rating <= merge(rating, s_axi_wdata, s_axi_wstrb);
				OFS_STALL:
					stall <= merge(stall, s_axi_wdata, s_axi_wstrb);
				OFS_FREQ:
					freqCfg <= merge(freqCfg, s_axi_wdata, s_axi_wstrb);
				OFS_RAMPA:
					rampA <= merge(rampA, s_axi_wdata, s_axi_wstrb);
				OFS_RAMPB:
					rampB <= merge(rampB, s_axi_wdata, s_axi_wstrb);
				OFS_AUX:
					if (s_axi_wstrb[0])
						auxFunc <= s_axi_wdata[7:0];
				default: ;
			endcase
		end
	end

	logic [31:0] statusWord;
	logic [31:0] rdWord;
	assign statusWord = {20'h0, useAltRamp, fan_warn_only,
		suppressVoltage, decelRequest, stallHold, outputCutoff, faults,
		olAlarm};
	always_comb
	begin
		case (s_axi_araddr)
			OFS_CTRL:   rdWord = ctrl;
			OFS_OLWARN: rdWord = olWarn;
			OFS_OLTRIP: rdWord = olTrip;
			OFS_RATING: rdWord = rating;
			OFS_STALL:  rdWord = stall;
			OFS_FREQ:   rdWord = freqCfg;
			OFS_RAMPA:  rdWord = rampA;
			OFS_RAMPB:  rdWord = rampB;
			OFS_AUX:    rdWord = {24'h0, auxFunc};
			OFS_STATUS: rdWord = statusWord;
			OFS_SAVED:  rdWord = {16'h0, savedFreq};
			OFS_FAULT:  rdWord = {27'h0, faults};
			default:    rdWord = 32'h0;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdWord;
			s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ---------------------------------------------------------------
	// overload alarm and trip
	// ---------------------------------------------------------------
	logic [31:0] tickCnt;
	logic        tick;
	logic [23:0] curPct;
	logic        aboveWarn, aboveTrip, holdDone, tripDone, warnDone;
	logic [15:0] warnCnt, holdCnt, tripCnt;
	assign tick = tickCnt == 32'(TICK - 1);
	always_ff @(posedge mclk)
		tickCnt <= (rst || tick) ? 32'h0 : tickCnt + 32'h1;

	assign curPct = 24'(outCurrent) * 24'h000064;
	assign aboveWarn = curPct >= 24'(rating[15:0]) * 24'(olWarn[7:0]);
	assign aboveTrip = curPct > 24'(rating[15:0]) * 24'(olTrip[7:0]);
	assign warnDone = warnCnt >= olWarn[31:16];
	assign holdDone = holdCnt >= olWarn[31:16];
	assign tripDone = tripCnt >= olTrip[31:16];

	always_ff @(posedge mclk)
	begin
		if (rst || !aboveWarn)
			warnCnt <= 16'h0;
		else if (tick && !warnDone)
			warnCnt <= warnCnt + 16'h1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || aboveWarn || !olAlarm)
			holdCnt <= 16'h0;
		else if (tick && !holdDone)
			holdCnt <= holdCnt + 16'h1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			olAlarm <= 1'b0;
		else if (aboveWarn && warnDone)
			olAlarm <= 1'b1;
		else if (!aboveWarn && holdDone)
			olAlarm <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || !aboveTrip)
			tripCnt <= 16'h0;
		else if (tick && !tripDone)
			tripCnt <= tripCnt + 16'h1;
	end

	// ---------------------------------------------------------------
	// latched faults: overload, out phase, in phase, contactor, fan
	// ---------------------------------------------------------------
	logic [2:0] plSel;
	logic [1:0] fanPol;
	logic       contPrev;
	logic [4:0] faultSet;
	logic [4:0] faultClr;
	assign plSel = ctrl[CTRL_PL +: 3];
	assign fanPol = ctrl[CTRL_FAN +: 2];
	always_ff @(posedge mclk)
		contPrev <= rst ? 1'b0 : contS;
	assign faultSet[0] = aboveTrip && tripDone;
	assign faultSet[1] = outPlS && plSel[0];
	assign faultSet[2] = inPlS && plSel[1];
	assign faultSet[3] = (contS != contPrev) && plSel[2];
	assign faultSet[4] = fanS && fanPol == FAN_TRIP;
	assign faultClr = (wrEn && wrAddr == OFS_FAULT && s_axi_wstrb[0]) ?
		s_axi_wdata[4:0] : 5'h0;
	// a new event in the clearing cycle survives the clear
	always_ff @(posedge mclk)
		faults <= rst ? 5'h0 : (faults & ~faultClr) | faultSet;
	assign outputCutoff = |faults;
	assign fan_warn_only = fanS && fanPol == FAN_WARN;

	always_ff @(posedge mclk)
	begin
		if (rst)
			programmable_output_terminal <= 1'b0;
		else
			programmable_output_terminal <=
				(auxFunc == AUX_OL && olAlarm) ||
				(auxFunc == AUX_FAN_WARN && fan_warn_only);
	end

	// ---------------------------------------------------------------
	// stall prevention
	// ---------------------------------------------------------------
	logic [31:0] stallRaw, stallCap, effLevel, curFreq, lvlBase;
	logic        stallHit, modeOn;
	logic [2:0]  stallEn;
	assign stallEn = ctrl[CTRL_STALL +: 3];
	assign stallRaw = 32'(rating[15:0]) * 32'(stall[7:0]) / 32'd100;
	assign stallCap = 32'(rating[31:16]) * STALL_CAP_PCT / 32'd100;
	assign effLevel = stallRaw > stallCap ? stallCap : stallRaw;
	// above base the level scales by base/freq; cross-multiplied
	assign curFreq = 32'(outCurrent) * 32'(outFreq);
	assign lvlBase = effLevel * 32'(stall[31:16]);
	assign stallHit = outFreq > stall[31:16] ?
		curFreq >= lvlBase : 32'(outCurrent) >= effLevel;
	assign modeOn = |(stallEn & rampMode);
	always_ff @(posedge mclk)
		stallHold <= rst ? 1'b0 : stallHit && modeOn;
	always_ff @(posedge mclk)
		decelRequest <= rst ? 1'b0 : stallHold && stopCmd;

	// ---------------------------------------------------------------
	// ramp selection
	// ---------------------------------------------------------------
	logic [15:0] chgFreq;
	logic [31:0] rampSet;
	assign chgFreq = freqCfg[15:0];
	// multi-ramp inputs override the change frequency
	assign useAltRamp = chgFreq != 16'h0 && outFreq < chgFreq &&
		mrS == 3'b000;
	assign rampSet = useAltRamp ? rampB : rampA;
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rampTime <= 16'h0;
			rampSpan <= 16'h0;
			rampUnitCycles <= 32'h0;
		end
		else
		begin
			rampTime <= rampMode == RAMP_DECEL ?
				rampSet[31:16] : rampSet[15:0];
			if (!ctrl[CTRL_DELTA])
				rampSpan <= freqCfg[31:16];
			else if (targetFreq > outFreq)
				rampSpan <= targetFreq - outFreq;
			else
				rampSpan <= outFreq - targetFreq;
			case (ctrl[CTRL_SCALE +: 2])
				2'h0: rampUnitCycles <= 32'(UNIT);
				2'h1: rampUnitCycles <= 32'(UNIT * 10);
				default: rampUnitCycles <= 32'(UNIT * 100);
			endcase
		end
	end

	// ---------------------------------------------------------------
	// up/down save and voltage suppression
	// ---------------------------------------------------------------
	logic udPrev;
	always_ff @(posedge mclk)
		udPrev <= rst ? 1'b0 : udS;
	always_ff @(posedge mclk)
	begin
		if (rst || clrS)
			savedFreq <= 16'h0;
		else if (ctrl[CTRL_UDSAVE] && udPrev && !udS)
			savedFreq <= outFreq;
	end
	assign saved_frequency_display = savedFreq;
	always_ff @(posedge mclk)
		suppressVoltage <= rst ? 1'b0 : ctrl[CTRL_SUPP] &&
			curPct < 24'(rating[15:0]) * LOWCUR_PCT;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	AST_WARN_SET: assert property (
		aboveWarn && warnDone |=> olAlarm)
		else $error("overload alarm not raised");
	AST_WARN_HOLD: assert property (
		$fell(olAlarm) |-> $past(holdDone) && !$past(aboveWarn))
		else $error("overload alarm dropped early");
	AST_AUX_OL: assert property (
		auxFunc == AUX_OL && olAlarm |=> programmable_output_terminal)
		else $error("aux output missed overload alarm");
	AST_TRIP: assert property (
		aboveTrip && tripDone |=> faults[0] ##0 outputCutoff)
		else $error("overload trip not latched");
	AST_OUT_PL: assert property (
		outPlS && plSel[0] |=> outputCutoff)
		else $error("output phase loss not cut");
	AST_IN_PL: assert property (
		!$past(plSel[1]) && !$past(faults[2]) |-> !faults[2])
		else $error("input phase fault while disabled");
	AST_CAP: assert property (
		outFreq <= stall[31:16] &&
		32'(outCurrent) * 32'd100 >= 32'(rating[31:16]) * STALL_CAP_PCT
		|-> stallHit)
		else $error("stall level above drive cap");
	AST_STOP: assert property (
		stallHold && stopCmd |=> decelRequest)
		else $error("stop in stall did not decelerate");
	AST_SAVE: assert property (
		ctrl[CTRL_UDSAVE] && udPrev && !udS && !clrS
		|=> savedFreq == $past(outFreq))
		else $error("frequency not saved");
	AST_FAN: assert property (
		$past(fanPol) == FAN_IGNORE && !$past(faults[4]) |-> !faults[4])
		else $error("fan fault not ignored");
	COV_ALARM: cover property ($rose(olAlarm));
	COV_TRIP: cover property ($rose(faults[0]));
	COV_STALL_STOP: cover property (stallHold && stopCmd);
	COV_SAVE: cover property (ctrl[CTRL_UDSAVE] && $fell(udS));
endmodule

// [verilog/dlps_pkg.sv]
package dlps_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ      = 100_000_000;
	localparam int TICK_MS     = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int UNIT_MS     = 10;
	localparam int UNIT_CYCLES = CLK_HZ / 1000 * UNIT_MS;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_OLWARN = 8'h04;
	localparam logic [7:0] OFS_OLTRIP = 8'h08;
	localparam logic [7:0] OFS_RATING = 8'h0c;
	localparam logic [7:0] OFS_STALL  = 8'h10;
	localparam logic [7:0] OFS_FREQ   = 8'h14;
	localparam logic [7:0] OFS_RAMPA  = 8'h18;
	localparam logic [7:0] OFS_RAMPB  = 8'h1c;
	localparam logic [7:0] OFS_AUX    = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_SAVED  = 8'h28;
	localparam logic [7:0] OFS_FAULT  = 8'h2c;
	// ---------------------------------------------------------------
	// control fields
	// ---------------------------------------------------------------
	localparam int CTRL_UDSAVE = 0;
	localparam int CTRL_SUPP   = 1;
	localparam int CTRL_DELTA  = 2;
	localparam int CTRL_SCALE  = 3;
	localparam int CTRL_FAN    = 5;
	localparam int CTRL_PL     = 7;
	localparam int CTRL_STALL  = 10;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] RST_CTRL   = 32'h0000_0128;
	localparam logic [31:0] RST_OLWARN = 32'h0064_006e;
	localparam logic [31:0] RST_OLTRIP = 32'h003c_00b4;
	localparam logic [31:0] RST_RATING = 32'h0064_0064;
	localparam logic [31:0] RST_STALL  = 32'h1770_0096;
	localparam logic [31:0] RST_FREQ   = 32'h1770_0000;
	localparam logic [31:0] RST_RAMP   = 32'h0064_0064;
	localparam logic [7:0]  RST_AUX    = 8'h00;
	// ---------------------------------------------------------------
	// codes and limits
	// ---------------------------------------------------------------
	localparam logic [7:0]  AUX_OL       = 8'h06;
	localparam logic [7:0]  AUX_FAN_WARN = 8'h15;
	localparam logic [1:0]  FAN_IGNORE   = 2'h0;
	localparam logic [1:0]  FAN_WARN     = 2'h1;
	localparam logic [1:0]  FAN_TRIP     = 2'h2;
	localparam logic [31:0] STALL_CAP_PCT = 32'h0000_0078;
	localparam logic [23:0] LOWCUR_PCT   = 24'h00000a;
	localparam int          NSYNC        = 8;
	typedef enum logic [2:0]
	{
		RAMP_ACCEL  = 3'b001,
		RAMP_STEADY = 3'b010,
		RAMP_DECEL  = 3'b100
	} ramp_mode_type;
endpackage

// [tb/dlps_plant.sv]
`timescale 1ns/1ps
module dlps_plant
(
	input  wire logic [15:0] load,
	input  wire logic [15:0] freqCmd,
	input  wire logic        outputCutoff,
	output logic [15:0]      outCurrent,
	output logic [15:0]      outFreq
);
	// ---------------------------------------------------------------
	// power stage and current sense
	// ---------------------------------------------------------------
	// a blocked bridge carries no current, so a tripped drive cannot
	// keep feeding its own overload timers
	assign outCurrent = outputCutoff ? 16'h0000 : load;
	assign outFreq    = freqCmd;
endmodule

// [tb/drive_load_protection_supervisor_tb.sv]
`timescale 1ns/1ps
module drive_load_protection_supervisor_tb;
	import dlps_pkg::*;
	localparam int TK = 10;
	localparam int UN = 4;
	logic          mclk = 0;
	logic          rst = 1;
	logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic          s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0]   s_axi_wdata = 32'h0000_0000;
	logic [3:0]    s_axi_wstrb = 4'hf;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic          s_axi_arready, s_axi_rvalid;
	logic [1:0]    s_axi_bresp, s_axi_rresp, rs;
	logic [31:0]   s_axi_rdata, rd, rampUnitCycles;
	logic [15:0]   load = 16'h0000, freqCmd = 16'h0000;
	logic [15:0]   targetFreq = 16'h0000, outCurrent, outFreq;
	logic [15:0]   rampTime, rampSpan, saved_frequency_display;
	ramp_mode_type rampMode = RAMP_ACCEL;
	logic          stopCmd = 0, outPhaseLoss = 0, inPhaseLoss = 0;
	logic          contactorState = 0, fanFault = 0, updownActive = 0;
	logic          savedClear = 0, multi_ramp_select_low = 0;
	logic          multi_ramp_select_mid = 0, multi_ramp_select_high = 0;
	logic          programmable_output_terminal, olAlarm, outputCutoff;
	logic          stallHold, decelRequest, suppressVoltage;
	logic          fan_warn_only, useAltRamp;
	int            n_mismatch = 0;
	int            n_tests = 0;
	logic [7:0]    regOfs [9] = '{OFS_CTRL, OFS_OLWARN, OFS_OLTRIP,
		OFS_RATING, OFS_STALL, OFS_FREQ, OFS_RAMPA, OFS_RAMPB, OFS_AUX};
	logic [31:0]   regVal [9] = '{RST_CTRL, RST_OLWARN, RST_OLTRIP,
		RST_RATING, RST_STALL, RST_FREQ, RST_RAMP, RST_RAMP, {24'h0, RST_AUX}};

	always #5 mclk = ~mclk;

	drive_load_protection_supervisor #(.TICK(TK), .UNIT(UN)) i_dut
	(
		.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .outCurrent, .outFreq, .targetFreq,
		.rampMode, .stopCmd, .outPhaseLoss, .inPhaseLoss, .contactorState,
		.fanFault, .updownActive, .savedClear, .multi_ramp_select_low,
		.multi_ramp_select_mid, .multi_ramp_select_high,
		.programmable_output_terminal, .olAlarm, .outputCutoff, .stallHold,
		.decelRequest, .suppressVoltage, .fan_warn_only, .useAltRamp,
		.rampTime, .rampSpan, .rampUnitCycles, .saved_frequency_display
	);

	dlps_plant i_plant (.load, .freqCmd, .outputCutoff, .outCurrent, .outFreq);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do @(negedge mclk); while (!(s_axi_awready && s_axi_wready));
		@(posedge mclk);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		do @(negedge mclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		@(posedge mclk);
		s_axi_bready <= 0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge mclk); while (!s_axi_arready);
		@(posedge mclk);
		s_axi_arvalid <= 0;
		do @(negedge mclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge mclk);
		s_axi_rready <= 0;
	endtask

	task automatic pin(input int k, input logic v);
		case (k)
			0: outPhaseLoss <= v;
			1: inPhaseLoss <= v;
			default: contactorState <= v;
		endcase
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		for (int i = 0; i < 9; i++)
		begin
			rdr(regOfs[i]);
			chk("reset value", rd, regVal[i]);
		end
		rdr(8'h30);
		chk("unmapped rresp", 32'(rs), 32'h2);
		wr(8'h02, 32'h0000_00ff);
		chk("unaligned bresp", 32'(rs), 32'h2);
		$display("register defaults done");
	endtask

	task automatic t_overload;
		wr(OFS_RATING, 32'h0064_00c8);
		wr(OFS_OLWARN, 32'h0003_006e);
		wr(OFS_AUX, {24'h0, AUX_OL});
		load <= 16'd219;
		cyc(50);
		chk("alarm below level", olAlarm, 0);
		load <= 16'd220;
		cyc(15);
		load <= 16'd0;
		cyc(5);
		load <= 16'd220;
		cyc(15);
		@(negedge mclk);
		chk("alarm after restart", olAlarm, 0);
		cyc(35);
		@(negedge mclk);
		chk("alarm raised", olAlarm, 1);
		chk("aux terminal", programmable_output_terminal, 1);
		chk("cutoff on alarm", outputCutoff, 0);
		@(posedge mclk);
		load <= 16'd0;
		cyc(15);
		@(negedge mclk);
		chk("alarm held", olAlarm, 1);
		cyc(35);
		@(negedge mclk);
		chk("alarm released", olAlarm, 0);
		$display("overload alarm done");
	endtask

	task automatic t_trip;
		wr(OFS_OLTRIP, 32'h0002_00b4);
		load <= 16'd360;
		cyc(50);
		@(negedge mclk);
		chk("cutoff at trip level", outputCutoff, 0);
		@(posedge mclk);
		load <= 16'd361;
		cyc(40);
		@(negedge mclk);
		chk("cutoff over trip level", outputCutoff, 1);
		rdr(OFS_FAULT);
		chk("overload fault", rd, 32'h1);
		load <= 16'd0;
		wr(OFS_FAULT, 32'h1);
		@(negedge mclk);
		chk("fault cleared", outputCutoff, 0);
		$display("overload trip done");
	endtask

	task automatic t_phase;
		for (int k = 0; k < 3; k++)
			for (int e = 0; e < 2; e++)
			begin
				wr(OFS_CTRL, 32'h8 | 32'(e << (7 + k)));
				pin(k, 1);
				cyc(6);
				pin(k, 0);
				cyc(6);
				@(negedge mclk);
				chk("phase cutoff", outputCutoff, 32'(e));
				rdr(OFS_FAULT);
				chk("phase fault", rd, 32'(e << (k + 1)));
				wr(OFS_FAULT, 32'h1f);
			end
		$display("phase loss done");
	endtask

	task automatic t_fan;
		wr(OFS_AUX, {24'h0, AUX_FAN_WARN});
		for (int p = 0; p < 3; p++)
		begin
			wr(OFS_CTRL, 32'h8 | 32'(p << 5));
			fanFault <= 1;
			cyc(6);
			@(negedge mclk);
			chk("fan warn", fan_warn_only, 32'(p == 1));
			chk("fan aux", programmable_output_terminal, 32'(p == 1));
			chk("fan cutoff", outputCutoff, 32'(p == 2));
			@(posedge mclk);
			fanFault <= 0;
			cyc(6);
			wr(OFS_FAULT, 32'h1f);
		end
		$display("fan policy done");
	endtask

	task automatic t_stall;
		// 200 % of motor would exceed the drive cap, so 120 units rule
		wr(OFS_STALL, 32'h1770_00c8);
		wr(OFS_CTRL, 32'h0000_0408);
		freqCmd <= 16'd3000;
		load <= 16'd119;
		cyc(5);
		@(negedge mclk);
		chk("stall under cap", stallHold, 0);
		@(posedge mclk);
		load <= 16'd125;
		cyc(5);
		@(negedge mclk);
		chk("stall over cap", stallHold, 1);
		@(posedge mclk);
		rampMode <= RAMP_STEADY;
		cyc(5);
		@(negedge mclk);
		chk("stall steady off", stallHold, 0);
		@(posedge mclk);
		rampMode <= RAMP_ACCEL;
		load <= 16'd119;
		freqCmd <= 16'd12000;
		cyc(5);
		@(negedge mclk);
		chk("stall above base", stallHold, 1);
		@(posedge mclk);
		stopCmd <= 1;
		cyc(5);
		@(negedge mclk);
		chk("decel on stop", decelRequest, 1);
		// status word: stall request in bit 7, decel request in bit 8
		rdr(OFS_STATUS);
		chk("status word", rd, 32'h0000_0180);
		@(posedge mclk);
		stopCmd <= 0;
		load <= 16'd0;
		$display("stall prevention done");
	endtask

	task automatic t_ramp;
		for (int s = 0; s < 3; s++)
		begin
			wr(OFS_CTRL, 32'(s << 3));
			cyc(3);
			@(negedge mclk);
			chk("ramp unit", rampUnitCycles,
				32'(s == 0 ? UN : s == 1 ? UN * 10 : UN * 100));
		end
		chk("span max", rampSpan, 32'd6000);
		freqCmd <= 16'd1000;
		targetFreq <= 16'd4000;
		wr(OFS_CTRL, 32'h0c);
		cyc(3);
		@(negedge mclk);
		chk("span delta", rampSpan, 32'd3000);
		@(posedge mclk);
		freqCmd <= 16'd500;
		// alternate set differs from the main set so the pick is visible
		wr(OFS_RAMPB, 32'h0032_0019);
		wr(OFS_FREQ, 32'h1770_03e8);
		@(negedge mclk);
		chk("alt ramp below", useAltRamp, 1);
		chk("alt accel time", rampTime, 32'd25);
		@(posedge mclk);
		rampMode <= RAMP_DECEL;
		cyc(2);
		@(negedge mclk);
		chk("alt decel time", rampTime, 32'd50);
		@(posedge mclk);
		rampMode <= RAMP_ACCEL;
		freqCmd <= 16'd1500;
		cyc(2);
		@(negedge mclk);
		chk("alt ramp above", useAltRamp, 0);
		@(posedge mclk);
		freqCmd <= 16'd500;
		multi_ramp_select_low <= 1;
		cyc(5);
		@(negedge mclk);
		chk("multi ramp wins", useAltRamp, 0);
		chk("main accel time", rampTime, 32'd100);
		@(posedge mclk);
		multi_ramp_select_low <= 0;
		$display("ramp select done");
	endtask

	task automatic t_saved;
		freqCmd <= 16'd1234;
		wr(OFS_CTRL, 32'h0b);
		updownActive <= 1;
		cyc(4);
		updownActive <= 0;
		cyc(6);
		@(negedge mclk);
		chk("saved freq", saved_frequency_display, 32'd1234);
		rdr(OFS_SAVED);
		chk("saved read", rd, 32'd1234);
		savedClear <= 1;
		cyc(4);
		savedClear <= 0;
		cyc(4);
		@(negedge mclk);
		chk("saved clear", saved_frequency_display, 0);
		chk("suppress on", suppressVoltage, 1);
		@(posedge mclk);
		load <= 16'd100;
		cyc(3);
		@(negedge mclk);
		chk("suppress loaded", suppressVoltage, 0);
		@(posedge mclk);
		load <= 16'd0;
		wr(OFS_CTRL, 32'h09);
		cyc(3);
		@(negedge mclk);
		chk("suppress off", suppressVoltage, 0);
		$display("saved freq and suppress done");
	endtask

	// ---------------------------------------------------------------
	// run control
	// ---------------------------------------------------------------
	task automatic results;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		cyc(3);
		rst <= 0;
		t_regs;
		t_overload;
		t_trip;
		t_phase;
		t_fan;
		t_stall;
		t_ramp;
		t_saved;
		results;
	end

	// the whole run needs well under a thousand cycles; this leaves wide margin
	initial
	begin
		cyc(20000);
		n_mismatch++;
		results;
	end
endmodule
